// *** inc/biop_pkg.sv ***
// package for the bidirectional read-modify-write io port
package biop_pkg;

  localparam int PORT_W = 8;
  localparam logic [7:0] LATCH_RST = 8'h00;
  // all pins start as inputs
  localparam logic [7:0] DIR_RST = 8'hff;
  // instruction cycle length in system clocks
  localparam int QCYC_LEN = 4;
  localparam logic [1:0] Q_LAST = 2'h3;

  // register selects seen by the core
  localparam logic [0:0] SEL_DATA = 1'h0;
  localparam logic [0:0] SEL_DIR = 1'h1;

  // core operations
  typedef enum logic [1:0] {
    BIOP_OP_NONE = 2'h0,
    BIOP_OP_WRITE = 2'h1,
    BIOP_OP_BSET = 2'h3,
    BIOP_OP_BCLR = 2'h2
  } biop_op_t;

  typedef struct packed {
    biop_op_t op;
    logic [0:0] sel;
    logic [2:0] bit_idx;
    logic [7:0] wdata;
  } biop_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } biop_pad_t;

endpackage : biop_pkg

// *** logic/biop_sync3.sv ***
// three-stage synchroniser with agreement filter for the pin inputs
`timescale 1ns/10ps
`default_nettype none
module biop_sync3 #(
  parameter int W = 8
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a pin change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          sync_o[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          sync_o[g] <= s3_q[g];
        end
      end
    end
  endgenerate
endmodule // biop_sync3

`default_nettype wire

// *** logic/biop_port.sv ***
// 8-bit bidirectional io port with latch, direction and read-modify-write
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - every bit set and bit clear is done as a whole-register read, modify inside, then full write-back; a write stores wdata as given.
// - reading the data register returns the live pin levels, not the latch contents.
// - a write to the data register stores the value in the output latches whatever the directions are.
// - a data bit operation reads all pins, so an input pin's level is written back into its own latch.
// - a latch value, including one overwritten while the pin was an input, drives the pin once it becomes an output.
// - latches update at the end of the instruction cycle that performs the write.
// - read data is sampled from the pins at the start of the instruction cycle.
// - a direction bit of one makes the pin an input, zero makes it an output.
module biop_port (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire biop_pkg::biop_req_t req_i,
  output logic req_ready_o,
  output logic [7:0] rdata_o,
  output logic [7:0] port_b_direction_o,
  output logic [7:0] io_port_b_data_latch_o,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic cyc_start_o
);
  typedef enum logic [1:0] {
    BIOP_Q1 = 2'h0,
    BIOP_Q2 = 2'h1,
    BIOP_Q3 = 2'h3,
    BIOP_Q4 = 2'h2
  } biop_q_t;

  biop_q_t q_q;
  logic [7:0] pins_sync;
  logic [7:0] latch_q;
  logic [7:0] dir_q;
  logic [7:0] sample_q;
  logic [7:0] rdata_q;
  biop_pkg::biop_req_t req_q;
  biop_pkg::biop_pad_t pad;

  function automatic logic [7:0] biop_modify(input biop_pkg::biop_req_t r, input logic [7:0] v);
    logic [7:0] m;
    m = 8'h01 << r.bit_idx;
    case (r.op)
      biop_pkg::BIOP_OP_WRITE: biop_modify = r.wdata;
      biop_pkg::BIOP_OP_BSET: biop_modify = v | m;
      biop_pkg::BIOP_OP_BCLR: biop_modify = v & ~m;
      default: biop_modify = v;
    endcase
  endfunction

  // a held request commits to the register that it selects at the end of the cycle
  function automatic logic biop_commits(input biop_pkg::biop_req_t r, input logic [0:0] s);
    biop_commits = (r.op != biop_pkg::BIOP_OP_NONE) && (r.sel == s);
  endfunction

  biop_sync3 #(
    .W(biop_pkg::PORT_W)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .async_i(pin_i),
    .sync_o(pins_sync)
  );

  // four-phase instruction cycle
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_q <= BIOP_Q1;
    end else begin
      case (q_q)
        BIOP_Q1: q_q <= BIOP_Q2;
        BIOP_Q2: q_q <= BIOP_Q3;
        BIOP_Q3: q_q <= BIOP_Q4;
        BIOP_Q4: q_q <= BIOP_Q1;
        default: q_q <= BIOP_Q1;
      endcase
    end
  end

  assign cyc_start_o = (q_q == BIOP_Q1);
  // the core presents one request per cycle, taken at its start
  assign req_ready_o = (q_q == BIOP_Q1);

  // request capture and pin sample at cycle start
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_q <= '0;
      sample_q <= 8'h00;
    end else if (q_q == BIOP_Q1) begin
      req_q <= req_i;
      sample_q <= pins_sync;
    end
  end

  // read data for the core, held for the whole cycle
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else if (q_q == BIOP_Q1) begin
      rdata_q <= (req_i.sel == biop_pkg::SEL_DATA) ? pins_sync : dir_q;
    end
  end
  assign rdata_o = rdata_q;

  // latch write-back at end of cycle
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      latch_q <= biop_pkg::LATCH_RST;
    end else if (q_q == BIOP_Q4 && biop_commits(req_q, biop_pkg::SEL_DATA)) begin
      latch_q <= biop_modify(req_q, sample_q);
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dir_q <= biop_pkg::DIR_RST;
    end else if (q_q == BIOP_Q4 && biop_commits(req_q, biop_pkg::SEL_DIR)) begin
      dir_q <= biop_modify(req_q, dir_q);
    end
  end

  always_comb begin
    pad.out = latch_q;
    pad.oe = ~dir_q;
  end

  assign pin_o = pad.out;
  assign pin_oe_o = pad.oe;
  assign port_b_direction_o = dir_q;
  assign io_port_b_data_latch_o = latch_q;

  // checks
  // latches and direction only move at the edge that closes a cycle
  a_latch_end_cycle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q != BIOP_Q4)
    |=> $stable(latch_q))
    else $error("latch changed mid cycle");
  a_dir_end_cycle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q != BIOP_Q4)
    |=> $stable(dir_q))
    else $error("direction changed mid cycle");
  a_idle_no_change: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q == BIOP_Q4 && req_q.op == biop_pkg::BIOP_OP_NONE)
    |=> $stable(latch_q) && $stable(dir_q))
    else $error("idle cycle changed a register");
  a_cycle_four: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    cyc_start_o
    |=> (!cyc_start_o) [*3] ##1 cyc_start_o)
    else $error("cycle not four clocks");

  // a full write lands whatever the directions are
  a_write_stores: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q == BIOP_Q4 && req_q.op == biop_pkg::BIOP_OP_WRITE && req_q.sel == biop_pkg::SEL_DATA)
    |=> latch_q == $past(req_q.wdata))
    else $error("write not stored");
  a_dir_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q == BIOP_Q4 && req_q.op == biop_pkg::BIOP_OP_WRITE && req_q.sel == biop_pkg::SEL_DIR)
    |=> port_b_direction_o == $past(req_q.wdata))
    else $error("direction write lost");

  // data bit operations modify the pin sample, not the latch; direction bit operations modify the direction register
  a_rmw_pins: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q == BIOP_Q4 && req_q.op == biop_pkg::BIOP_OP_BSET && req_q.sel == biop_pkg::SEL_DATA)
    |=> latch_q == ($past(sample_q) | (8'h01 << $past(req_q.bit_idx))))
    else $error("bit set wrong");
  a_rmw_clr: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q == BIOP_Q4 && req_q.op == biop_pkg::BIOP_OP_BCLR && req_q.sel == biop_pkg::SEL_DATA)
    |=> latch_q == ($past(sample_q) & ~(8'h01 << $past(req_q.bit_idx))))
    else $error("bit clear wrong");
  a_input_written: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q == BIOP_Q4 && req_q.sel == biop_pkg::SEL_DATA
     && (req_q.op == biop_pkg::BIOP_OP_BSET || req_q.op == biop_pkg::BIOP_OP_BCLR))
    |=> ((latch_q ^ $past(sample_q)) & $past(dir_q) & ~(8'h01 << $past(req_q.bit_idx))) == 8'h00)
    else $error("input pin level not written back");
  a_dir_bit_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q == BIOP_Q4 && req_q.op == biop_pkg::BIOP_OP_BSET && req_q.sel == biop_pkg::SEL_DIR)
    |=> dir_q == ($past(dir_q) | (8'h01 << $past(req_q.bit_idx))))
    else $error("direction bit set wrong");
  a_dir_bit_clr: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q == BIOP_Q4 && req_q.op == biop_pkg::BIOP_OP_BCLR && req_q.sel == biop_pkg::SEL_DIR)
    |=> dir_q == ($past(dir_q) & ~(8'h01 << $past(req_q.bit_idx))))
    else $error("direction bit clear wrong");

  // reads and the pin sample are taken at the cycle start and then held
  a_read_pins: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q == BIOP_Q1 && req_i.sel == biop_pkg::SEL_DATA)
    |=> rdata_o == $past(pins_sync))
    else $error("read not pin level");
  a_read_dir: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q == BIOP_Q1 && req_i.sel == biop_pkg::SEL_DIR)
    |=> rdata_o == $past(dir_q))
    else $error("direction read wrong");
  a_read_start: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q != BIOP_Q1)
    |=> $stable(rdata_o))
    else $error("read sampled late");
  a_sample_start: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q == BIOP_Q1)
    |=> sample_q == $past(pins_sync))
    else $error("pin sample not taken at start");
  a_sample_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q != BIOP_Q1)
    |=> $stable(sample_q))
    else $error("pin sample moved mid cycle");

  // pad drivers
  a_dir_oe: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    pin_oe_o == ~port_b_direction_o)
    else $error("enable not from direction");
  a_out_latch: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ((pin_o ^ io_port_b_data_latch_o) == 8'h00))
    else $error("pin not latch");

  // main scenarios
  c_bit_set: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    q_q == BIOP_Q4 && req_q.op == biop_pkg::BIOP_OP_BSET);
  c_input_overwrite: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    q_q == BIOP_Q4 && req_q.op == biop_pkg::BIOP_OP_BCLR && (dir_q & (sample_q ^ latch_q)) != 8'h00);
  c_turn_output: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $fell(dir_q[0]));
  c_dir_read: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    q_q == BIOP_Q1 && req_i.sel == biop_pkg::SEL_DIR && req_i.op != biop_pkg::BIOP_OP_NONE);
  c_stale_read: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (q_q == BIOP_Q4 && req_q.op == biop_pkg::BIOP_OP_WRITE && req_q.sel == biop_pkg::SEL_DATA)
    ##1 (req_ready_o && req_i.op != biop_pkg::BIOP_OP_NONE && req_i.sel == biop_pkg::SEL_DATA));
endmodule // biop_port

`default_nettype wire

// *** sim/biop_pins_model.sv ***
// pin-side model: external pull-ups and drivers on the port pins
`timescale 1ns/10ps
`default_nettype none
module biop_pins_model #(
  parameter logic [7:0] PULL_UP = 8'hc0
) (
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] ext_drv_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] pad_o
);
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      if (pad_oe_i[k]) begin
        pad_o[k] = pad_out_i[k];
      end else if (ext_en_i[k]) begin
        pad_o[k] = ext_drv_i[k];
      end else if (PULL_UP[k]) begin
        pad_o[k] = 1'b1;
      end else begin
        // a released line without pull shows the inverse of its output latch bit
        pad_o[k] = ~pad_out_i[k];
      end
    end
  end
endmodule // biop_pins_model
`default_nettype wire

// *** sim/tb_bidirectional_io_port_rmw.sv ***
// testbench for the bidirectional read-modify-write io port
`timescale 1ns/10ps
`default_nettype none
module tb_bidirectional_io_port_rmw;
  logic clk_sys_i, nrst_i, req_ready_o, cyc_start_o;
  biop_pkg::biop_req_t req_i;
  logic [7:0] rdata_o, dir_o, latch_o, pin_i, pin_o, pin_oe_o, ext_drv, rd;
  int err_count, n_tests, cyc;
  biop_port dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rdata_o(rdata_o), .port_b_direction_o(dir_o), .io_port_b_data_latch_o(latch_o), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .cyc_start_o(cyc_start_o));
  biop_pins_model pins (.pad_out_i(pin_o), .pad_oe_i(pin_oe_o), .ext_drv_i(ext_drv), .ext_en_i(8'h3f),
    .pad_o(pin_i));
  task automatic stop_test;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic issue(input biop_pkg::biop_op_t o, input logic s, input logic [2:0] b, input logic [7:0] w);
    for (int i = 0; i < 8 && req_ready_o !== 1'b1; i++) @(negedge clk_sys_i);
    chk("cyc_start", 8'h01, {7'h00, cyc_start_o});
    req_i = '{op: o, sel: s, bit_idx: b, wdata: w};
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    req_i.op = biop_pkg::BIOP_OP_NONE;
    chk("cyc_mid", 8'h00, {7'h00, cyc_start_o});
  endtask
  task automatic run(input biop_pkg::biop_op_t o, input logic s, input logic [2:0] b, input logic [7:0] w);
    logic [7:0] l0;
    l0 = latch_o;
    issue(o, s, b, w);
    chk("latch_early", l0, latch_o);
    @(negedge clk_sys_i);
    rd = rdata_o;
    repeat (3) @(negedge clk_sys_i);
  endtask
  task automatic t_reset;
    chk("dir_rst", 8'hff, dir_o);
    chk("oe_rst", 8'h00, pin_oe_o);
  endtask
  task automatic t_write_inputs;
    run(biop_pkg::BIOP_OP_WRITE, biop_pkg::SEL_DATA, 3'h0, 8'ha5);
    chk("latch_wr", 8'ha5, latch_o);
    chk("oe_wr", 8'h00, pin_oe_o);
  endtask
  task automatic t_dir_read;
    run(biop_pkg::BIOP_OP_WRITE, biop_pkg::SEL_DIR, 3'h0, 8'hf0);
    chk("oe_dir", 8'h0f, pin_oe_o);
    chk("pad_out", 8'ha5, pin_o);
    repeat (8) @(negedge clk_sys_i);
    run(biop_pkg::BIOP_OP_BCLR, biop_pkg::SEL_DATA, 3'h7, 8'h00);
    chk("rd_pins", 8'hc5, rd);
    chk("latch_rmw7", 8'h45, latch_o);
  endtask
  task automatic t_rmw_switch;
    run(biop_pkg::BIOP_OP_BCLR, biop_pkg::SEL_DATA, 3'h6, 8'h00);
    chk("latch_rmw6", 8'h85, latch_o);
    run(biop_pkg::BIOP_OP_BCLR, biop_pkg::SEL_DIR, 3'h7, 8'h00);
    chk("oe_sw", 8'h8f, pin_oe_o);
    chk("driven", 8'h85, pin_o & pin_oe_o);
  endtask
  task automatic t_back_to_back;
    repeat (8) @(negedge clk_sys_i);
    issue(biop_pkg::BIOP_OP_WRITE, biop_pkg::SEL_DATA, 3'h0, 8'h0a);
    issue(biop_pkg::BIOP_OP_BSET, biop_pkg::SEL_DATA, 3'h0, 8'h00);
    @(negedge clk_sys_i);
    chk("rd_old", 8'hc5, rdata_o);
    repeat (3) @(negedge clk_sys_i);
    chk("latch_b2b", 8'hc5, latch_o);
  endtask
  task automatic t_ext_input;
    @(negedge clk_sys_i);
    ext_drv = 8'h30;
    repeat (8) @(negedge clk_sys_i);
    run(biop_pkg::BIOP_OP_BSET, biop_pkg::SEL_DATA, 3'h3, 8'h00);
    chk("rd_ext", 8'hf5, rd);
    chk("latch_ext", 8'hfd, latch_o);
    chk("drive_ext", 8'h8d, pin_o & pin_oe_o);
    run(biop_pkg::BIOP_OP_BSET, biop_pkg::SEL_DIR, 3'h0, 8'h00);
    chk("rd_dir", 8'h70, rd);
    chk("dir_set", 8'h71, dir_o);
    chk("oe_set", 8'h8e, pin_oe_o);
  endtask
  task automatic t_reset_mid;
    nrst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk("latch_rst", biop_pkg::LATCH_RST, latch_o);
    chk("dir_rst2", biop_pkg::DIR_RST, dir_o);
    chk("rdata_rst", 8'h00, rdata_o);
    nrst_i = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    run(biop_pkg::BIOP_OP_NONE, biop_pkg::SEL_DATA, 3'h0, 8'h00);
    chk("rd_after_rst", 8'hf0, rd);
    chk("latch_none", 8'h00, latch_o);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    nrst_i = 1'b0;
    req_i = '{op: biop_pkg::BIOP_OP_NONE, sel: 1'h0, bit_idx: 3'h0, wdata: 8'h00};
    ext_drv = 8'h00;
    repeat (12) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    t_reset();
    t_write_inputs();
    t_dir_read();
    t_rmw_switch();
    t_back_to_back();
    t_ext_input();
    t_reset_mid();
    stop_test();
  end
endmodule // tb_bidirectional_io_port_rmw
`default_nettype wire
